// ### rtl/dma_channel_descriptor_status.sv
/*
 One DMA channel: descriptor fetch, beat engine, write-back, status.
 Assumes an Avalon-MM master for registers and an Avalon-MM slave
 memory system (response nonzero is a bus error) on the same clock.
*/
// Chosen here: the Avalon-MM slave port.
// Functional notes
// - Fetch error flag sets on invalid descriptor, clears on resume command.
// - Busy sets when transfer starts; clears on block end, bus error, disable.
// - Pending sets while waiting; clears on trigger start, bus error, disable.
// - Status register is read-only, resets to zero, upper bits read zero.
// - Descriptor lives at base or write-back base plus channel times 16.
// - Step field scales increment: beat size times two to the field value.
// - Step select zero steps destination, one steps source.
// - Destination fixed when its increment bit is zero, else advances.
// - Source fixed when its increment bit is zero, else advances.
// - Beat width field sets access width: 8, 16, 32 bits, 3 reserved.
// - Block action: none, interrupt, suspend, or both after a block.
// - Event output: off, strobe per block, strobe per beat, 2 reserved.
// - Fetching a descriptor with valid bit zero suspends the channel.
// - Write-back copy valid bit clears on abort, error, or block end.
// - 16-bit beat count; internal copy decrements once per beat.
// - Internal count written back on priority loss, suspend, or disable.
// - Channel disables on transfer end, transfer error, or software.
// - Source word is the address one increment past the last beat.
// - Destination word is the address one increment past the last beat.
// - Zero next-descriptor pointer ends the transaction.
// - Invalid fetch also sets transfer error and suspend flags.
`timescale 1ns/10ps
`include "dma_channel_map.svh"
module dma_channel_descriptor_status (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic trigger_i,
  input wire logic priority_lost_i,
  output logic [31:0] m_address_o,
  output logic m_read_o,
  output logic m_write_o,
  output logic [31:0] m_writedata_o,
  output logic [3:0] m_byteenable_o,
  input wire logic [31:0] m_readdata_i,
  input wire logic m_waitrequest_i,
  input wire logic [1:0] m_response_i,
  output logic event_o
);
  dma_channel_pkg::chan_state_t st_q;
  dma_channel_pkg::wb_cause_t why_q;
  logic ack_q;
  logic enable_q;
  logic fetch_error_flag_q;
  logic [2:0] intflag_q;
  logic [31:0] base_q;
  logic [31:0] wrb_q;
  logic [2:0] chnum_q;
  logic [15:0] ctrl_q;
  logic [15:0] cnt_q;
  logic [31:0] src_end_q;
  logic [31:0] dst_end_q;
  logic [31:0] next_q;
  logic [31:0] src_q;
  logic [31:0] dst_q;
  logic [31:0] data_q;
  logic [31:0] fetch_q;
  logic [1:0] word_q;
  logic evt_q;
  logic [7:0] status;
  logic [7:0] idx;
  logic wr_acc;
  logic rd_acc;
  logic resume_cmd;
  logic [31:0] chan_ofs;
  logic [31:0] wmask;
  logic [1:0] beat;
  logic [2:0] beat_bytes;
  logic [9:0] step_bytes;
  logic [31:0] src_inc;
  logic [31:0] dst_inc;
  logic [3:0] lane_be;
  logic xfer_done;
  logic bus_err;
  logic [2:0] flag_set;

  // One wait state: read data is registered before the answer edge
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
  assign idx = avs_address_i[9:2];
  assign wr_acc = avs_write_i & ack_q;
  assign rd_acc = avs_read_i & ~ack_q;
  assign resume_cmd = wr_acc && idx == `REG_CTRL_IDX && avs_writedata_i[`CTRL_RESUME];
  assign wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                  {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign chan_ofs = {25'h0000000, chnum_q, 4'h0} & ~(`DESC_STRIDE - 32'h1);

  assign beat = ctrl_q[`BT_BEAT_LO +: 2];
  assign beat_bytes = 3'h1 << beat;
  assign step_bytes = 10'({7'h00, beat_bytes} << ctrl_q[`BT_STEP_LO +: 3]);
  always_comb begin
    src_inc = 32'h0;
    dst_inc = 32'h0;
    if (ctrl_q[`BT_SOURCE_INCREMENT_ENABLE]) begin
      src_inc = ctrl_q[`BT_STEP_TARGET_SELECT] ? {22'h000000, step_bytes} : {29'h0, beat_bytes};
    end
    if (ctrl_q[`BT_DESTINATION_INCREMENT_ENABLE]) begin
      dst_inc = ctrl_q[`BT_STEP_TARGET_SELECT] ? {29'h0, beat_bytes} : {22'h000000, step_bytes};
    end
  end

  // Byte lanes of the current access, from the address low bits
  always_comb begin
    logic [1:0] a;
    a = (st_q == dma_channel_pkg::ST_WRITE) ? dst_q[1:0] : src_q[1:0];
    unique case (beat)
      2'h0: lane_be = 4'h1 << a;
      2'h1: lane_be = a[1] ? 4'hc : 4'h3;
      default: lane_be = 4'hf;
    endcase
  end

  assign xfer_done = (m_read_o | m_write_o) & ~m_waitrequest_i;
  assign bus_err = xfer_done && m_response_i != 2'h0;

  always_comb begin
    m_read_o = 1'b0;
    m_write_o = 1'b0;
    m_address_o = 32'h0;
    m_byteenable_o = 4'hf;
    unique case (st_q)
      dma_channel_pkg::ST_FETCH: begin
        m_read_o = 1'b1;
        m_address_o = fetch_q + {28'h0, word_q, 2'h0};
      end
      dma_channel_pkg::ST_READ: begin
        m_read_o = 1'b1;
        m_address_o = {src_q[31:2], 2'h0};
        m_byteenable_o = lane_be;
      end
      dma_channel_pkg::ST_WRITE: begin
        m_write_o = 1'b1;
        m_address_o = {dst_q[31:2], 2'h0};
        m_byteenable_o = lane_be;
      end
      dma_channel_pkg::ST_WB: begin
        m_write_o = 1'b1;
        m_address_o = wrb_q + chan_ofs;
      end
      default: begin
      end
    endcase
  end

  // Write-back word: count high, control low; valid kept only when resumable
  always_comb begin
    m_writedata_o = data_q;
    if (st_q == dma_channel_pkg::ST_WB) begin
      m_writedata_o = {cnt_q, ctrl_q};
      if (why_q != dma_channel_pkg::WB_LOST) begin
        m_writedata_o[`BT_VALID] = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      st_q <= dma_channel_pkg::ST_IDLE;
      why_q <= dma_channel_pkg::WB_DONE;
      word_q <= 2'h0;
      fetch_q <= 32'h0;
      ctrl_q <= 16'h0000;
      cnt_q <= 16'h0000;
      src_end_q <= 32'h0;
      dst_end_q <= 32'h0;
      next_q <= 32'h0;
      src_q <= 32'h0;
      dst_q <= 32'h0;
      data_q <= 32'h0;
      evt_q <= 1'b0;
      flag_set <= 3'h0;
    end else begin
      evt_q <= 1'b0;
      flag_set <= 3'h0;
      unique case (st_q)
        dma_channel_pkg::ST_IDLE: begin
          if (enable_q) begin
            fetch_q <= base_q + chan_ofs;
            word_q <= 2'h0;
            st_q <= dma_channel_pkg::ST_FETCH;
          end
        end
        dma_channel_pkg::ST_FETCH: begin
          if (bus_err) begin
            flag_set[`IF_XERR] <= 1'b1;
            st_q <= dma_channel_pkg::ST_IDLE;
          end else if (xfer_done) begin
            unique case (word_q)
              2'h0: begin
                ctrl_q <= m_readdata_i[15:0] & ~`BT_RSVD_MASK;
                cnt_q <= m_readdata_i[31:16];
              end
              2'h1: src_end_q <= m_readdata_i;
              2'h2: dst_end_q <= m_readdata_i;
              2'h3: next_q <= m_readdata_i;
            endcase
            word_q <= word_q + 2'h1;
            if (word_q == 2'h3) begin
              st_q <= dma_channel_pkg::ST_CHECK;
            end
          end
        end
        dma_channel_pkg::ST_CHECK: begin
          src_q <= src_end_q - 32'(cnt_q * src_inc);
          dst_q <= dst_end_q - 32'(cnt_q * dst_inc);
          if (!ctrl_q[`BT_VALID]) begin
            flag_set <= 3'h5;
            st_q <= dma_channel_pkg::ST_HOLD;
          end else if (beat == `BEAT_RSVD ||
                       ctrl_q[`BT_EVO_LO +: 2] == `EVO_RSVD) begin
            // Fault before any beat access, so no odd width ever reaches the bus
            flag_set[`IF_XERR] <= 1'b1;
            why_q <= dma_channel_pkg::WB_ERROR;
            st_q <= dma_channel_pkg::ST_WB;
          end else if (cnt_q == 16'h0000) begin
            fetch_q <= next_q;
            why_q <= dma_channel_pkg::WB_DONE;
            st_q <= dma_channel_pkg::ST_WB;
          end else begin
            st_q <= dma_channel_pkg::ST_WAIT;
          end
        end
        dma_channel_pkg::ST_WAIT: begin
          if (!enable_q) begin
            why_q <= dma_channel_pkg::WB_ABORT;
            st_q <= dma_channel_pkg::ST_WB;
          end else if (trigger_i) begin
            st_q <= dma_channel_pkg::ST_READ;
          end
        end
        dma_channel_pkg::ST_READ: begin
          if (bus_err) begin
            flag_set[`IF_XERR] <= 1'b1;
            why_q <= dma_channel_pkg::WB_ERROR;
            st_q <= dma_channel_pkg::ST_WB;
          end else if (xfer_done) begin
            // Pick the source lane and copy it to every lane for the write
            unique case (beat)
              2'h0: data_q <= {4{m_readdata_i[8*src_q[1:0] +: 8]}};
              2'h1: data_q <= {2{m_readdata_i[16*src_q[1] +: 16]}};
              default: data_q <= m_readdata_i;
            endcase
            st_q <= dma_channel_pkg::ST_WRITE;
          end
        end
        dma_channel_pkg::ST_WRITE: begin
          if (bus_err) begin
            flag_set[`IF_XERR] <= 1'b1;
            why_q <= dma_channel_pkg::WB_ERROR;
            st_q <= dma_channel_pkg::ST_WB;
          end else if (xfer_done) begin
            src_q <= src_q + src_inc;
            dst_q <= dst_q + dst_inc;
            cnt_q <= cnt_q - 16'h0001;
            evt_q <= ctrl_q[`BT_EVO_LO +: 2] == `EVO_BEAT;
            if (cnt_q == 16'h0001) begin
              evt_q <= ctrl_q[`BT_EVO_LO +: 2] != 2'h0;
              flag_set[`IF_TCMPL] <= ctrl_q[`BT_ACT_LO];
              flag_set[`IF_HOLD] <= ctrl_q[`BT_ACT_LO + 1];
              fetch_q <= next_q;
              why_q <= ctrl_q[`BT_ACT_LO + 1] ? dma_channel_pkg::WB_SUSPEND
                                              : dma_channel_pkg::WB_DONE;
              st_q <= dma_channel_pkg::ST_WB;
            end else if (!enable_q) begin
              why_q <= dma_channel_pkg::WB_ABORT;
              st_q <= dma_channel_pkg::ST_WB;
            end else if (priority_lost_i) begin
              why_q <= dma_channel_pkg::WB_LOST;
              st_q <= dma_channel_pkg::ST_WB;
            end else begin
              st_q <= dma_channel_pkg::ST_READ;
            end
          end
        end
        dma_channel_pkg::ST_WB: begin
          if (xfer_done) begin
            unique case (why_q)
              dma_channel_pkg::WB_LOST: st_q <= dma_channel_pkg::ST_WAIT;
              dma_channel_pkg::WB_SUSPEND: st_q <= dma_channel_pkg::ST_HOLD;
              dma_channel_pkg::WB_DONE: begin
                word_q <= 2'h0;
                st_q <= (fetch_q == `NEXT_END) ? dma_channel_pkg::ST_IDLE
                                               : dma_channel_pkg::ST_FETCH;
              end
              default: st_q <= dma_channel_pkg::ST_IDLE;
            endcase
          end
        end
        dma_channel_pkg::ST_HOLD: begin
          if (!enable_q) begin
            st_q <= dma_channel_pkg::ST_IDLE;
          end else if (resume_cmd) begin
            word_q <= 2'h0;
            st_q <= (fetch_q == `NEXT_END) ? dma_channel_pkg::ST_IDLE
                                           : dma_channel_pkg::ST_FETCH;
          end
        end
        default: st_q <= dma_channel_pkg::ST_IDLE;
      endcase
    end
  end

  assign event_o = evt_q;

  // Hardware disables the channel; a software enable in the same cycle wins
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      enable_q <= 1'b0;
    end else if (wr_acc && idx == `REG_CTRL_IDX) begin
      // Resume onto a zero next pointer ends the transaction despite the enable bit
      enable_q <= avs_writedata_i[`CTRL_ENABLE] &&
                  !(st_q == dma_channel_pkg::ST_HOLD && resume_cmd &&
                    fetch_q == `NEXT_END);
    end else if ((st_q == dma_channel_pkg::ST_FETCH && bus_err) ||
                 (st_q == dma_channel_pkg::ST_WB && xfer_done &&
                  (why_q == dma_channel_pkg::WB_ERROR ||
                   (why_q == dma_channel_pkg::WB_DONE && fetch_q == `NEXT_END)))) begin
      enable_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      fetch_error_flag_q <= 1'b0;
    end else if (st_q == dma_channel_pkg::ST_CHECK && !ctrl_q[`BT_VALID]) begin
      fetch_error_flag_q <= 1'b1;
    end else if (resume_cmd) begin
      fetch_error_flag_q <= 1'b0;
    end
  end

  // Write one to clear; a flag raised in the same cycle survives
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      intflag_q <= 3'h0;
    end else if (wr_acc && idx == `REG_INTFLAG_IDX) begin
      intflag_q <= (intflag_q & ~avs_writedata_i[2:0]) | flag_set;
    end else begin
      intflag_q <= intflag_q | flag_set;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      base_q <= 32'h0;
      wrb_q <= 32'h0;
      chnum_q <= 3'h0;
    end else if (wr_acc) begin
      if (idx == `REG_BASE_IDX) begin
        base_q <= (base_q & ~wmask) | (avs_writedata_i & wmask);
      end
      if (idx == `REG_WRB_IDX) begin
        wrb_q <= (wrb_q & ~wmask) | (avs_writedata_i & wmask);
      end
      if (idx == `REG_CHNUM_IDX) begin
        chnum_q <= avs_writedata_i[2:0];
      end
    end
  end

  assign status = {5'h00, fetch_error_flag_q,
                   st_q == dma_channel_pkg::ST_READ || st_q == dma_channel_pkg::ST_WRITE,
                   st_q == dma_channel_pkg::ST_WAIT};

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      ack_q <= 1'b0;
      avs_readdata_o <= 32'h0;
    end else begin
      ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
      if (rd_acc) begin
        unique case (idx)
          `REG_ACTCTL_IDX: avs_readdata_o <= {16'h0000, ctrl_q};
          `REG_SRCEND_IDX: avs_readdata_o <= src_end_q;
          `REG_CTRL_IDX: avs_readdata_o <= {31'h0, enable_q};
          `REG_BASE_IDX: avs_readdata_o <= base_q;
          `REG_WRB_IDX: avs_readdata_o <= wrb_q;
          `REG_CHNUM_IDX: avs_readdata_o <= {29'h0, chnum_q};
          `REG_INTFLAG_IDX: avs_readdata_o <= {29'h0, intflag_q};
          `REG_COUNT_IDX: avs_readdata_o <= {16'h0000, cnt_q};
          `REG_STATUS_IDX: avs_readdata_o <= {24'h000000, status};
          default: avs_readdata_o <= 32'h0;
        endcase
      end
    end
  end
endmodule : dma_channel_descriptor_status

// ### rtl/dma_channel_map.svh
/*
 Register indices, descriptor layout, field positions and codes of the
 DMA channel. Assumes byte addressing on the register bus, byte address
 equal to four times the index.
*/
`ifndef DMA_CHANNEL_MAP_SVH
`define DMA_CHANNEL_MAP_SVH
`define REG_ACTCTL_IDX 8'h00
`define REG_SRCEND_IDX 8'h04
`define REG_CTRL_IDX 8'h10
`define REG_BASE_IDX 8'h11
`define REG_WRB_IDX 8'h12
`define REG_CHNUM_IDX 8'h13
`define REG_INTFLAG_IDX 8'h14
`define REG_COUNT_IDX 8'h15
`define REG_STATUS_IDX 8'h4f
`define DESC_STRIDE 32'h00000010
`define DESC_WORD_STEP 32'h00000004
`define NEXT_END 32'h00000000
`define BT_VALID 0
`define BT_EVO_LO 1
`define BT_ACT_LO 3
`define BT_BEAT_LO 8
`define BT_SOURCE_INCREMENT_ENABLE 10
`define BT_DESTINATION_INCREMENT_ENABLE 11
`define BT_STEP_TARGET_SELECT 12
`define BT_STEP_LO 13
`define BT_RSVD_MASK 16'h00e0
`define STAT_WAIT 0
`define STAT_BUSY 1
`define STAT_FETCH_ERR 2
`define IF_XERR 0
`define IF_TCMPL 1
`define IF_HOLD 2
`define CTRL_ENABLE 0
`define CTRL_RESUME 1
`define BEAT_RSVD 2'h3
`define EVO_BLOCK 2'h1
`define EVO_RSVD 2'h2
`define EVO_BEAT 2'h3
`define STATUS_RESET 8'h00
`endif

// ### rtl/dma_channel_pkg.sv
/*
 Types of the DMA channel: sequencer states and write-back causes.
 Assumes nothing of its surroundings.
*/
package dma_channel_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_CHECK, ST_WAIT, ST_READ, ST_WRITE, ST_WB, ST_HOLD
  } chan_state_t;
  typedef enum logic [2:0] {
    WB_DONE, WB_SUSPEND, WB_ERROR, WB_ABORT, WB_LOST
  } wb_cause_t;
endpackage : dma_channel_pkg

// ### sim/dma_channel_monitor.sv
/*
 Port assertions of the DMA channel.
 Assumes a bind onto the channel top module, one clock, synchronous reset.
*/
`timescale 1ns/10ps
module dma_channel_monitor (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [31:0] m_address_o,
  input wire logic m_read_o,
  input wire logic m_write_o,
  input wire logic [31:0] m_writedata_o,
  input wire logic [3:0] m_byteenable_o,
  input wire logic m_waitrequest_i,
  input wire logic event_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);
  property p_one_wait;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("register wait too long");
  property p_status_upper;
    avs_read_i && !avs_waitrequest_o && avs_address_i[9:2] == 8'h4f
      |-> avs_readdata_o[31:3] == 29'h0;
  endproperty
  a_status_upper: assert property (p_status_upper) else $error("status upper bits");
  property p_lanes;
    m_read_o || m_write_o |-> m_byteenable_o inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf};
  endproperty
  a_lanes: assert property (p_lanes) else $error("undefined access width");
  property p_aligned;
    m_read_o || m_write_o |-> m_address_o[1:0] == 2'h0;
  endproperty
  a_aligned: assert property (p_aligned) else $error("unaligned address");
  property p_hold;
    (m_read_o || m_write_o) && m_waitrequest_i |=> $stable(m_address_o)
      && $stable({m_read_o, m_write_o, m_byteenable_o, m_writedata_o});
  endproperty
  a_hold: assert property (p_hold) else $error("request changed while stalled");
  property p_one_dir;
    !(m_read_o && m_write_o);
  endproperty
  a_one_dir: assert property (p_one_dir) else $error("read and write together");
  property p_ev_pulse;
    event_o |=> !event_o;
  endproperty
  a_ev_pulse: assert property (p_ev_pulse) else $error("event longer than a cycle");
  property p_ev_cause;
    event_o |-> $past(m_write_o && !m_waitrequest_i);
  endproperty
  a_ev_cause: assert property (p_ev_cause) else $error("event without write");
  // Reset itself must quiet the master, so this one is not disabled by it
  property p_reset_quiet;
    disable iff (1'b0) reset_i |=> !m_read_o && !m_write_o && !event_o;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("active after reset");
  c_event: cover property (event_o);
  c_byte_write: cover property (m_write_o && !m_waitrequest_i && m_byteenable_o == 4'h2);
  c_status_read: cover property (avs_read_i && avs_address_i[9:2] == 8'h4f);
endmodule : dma_channel_monitor
bind dma_channel_descriptor_status dma_channel_monitor u_dma_channel_monitor (.*);

// ### sim/dma_mem_model.sv
/*
 Avalon-MM memory on the channel's master side.
 Assumes the channel clock; unwritten words read an address pattern.
*/
`timescale 1ns/10ps
module dma_mem_model (
  input wire logic clk_i,
  input wire logic [31:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [3:0] byteenable_i,
  input wire logic [31:0] err_addr_i,
  input wire logic slow_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o,
  output logic [1:0] response_o
);
  logic [31:0] mem [logic [31:0]];
  logic [1:0] stall_q = 2'h0;
  logic [31:0] last_q = 32'h0;
  logic [31:0] w;
  logic ans;
  function automatic logic [31:0] peek(input logic [31:0] a);
    return mem.exists(a) ? mem[a] : a ^ 32'hc3a55a3c;
  endfunction : peek
  assign ans = (read_i || write_i) && stall_q == 2'h0;
  assign waitrequest_o = ~ans;
  // Idle bus shows the inverse of the last word so stale data never passes
  assign readdata_o = (ans && read_i) ? peek(address_i) : ~last_q;
  assign response_o = (ans && address_i == err_addr_i) ? 2'h2 : 2'h0;
  always @(posedge clk_i) begin
    if (read_i || write_i)
      stall_q <= ans ? {slow_i, 1'b0} : stall_q - 2'h1;
    if (ans)
      last_q <= readdata_o;
    if (ans && write_i && address_i != err_addr_i) begin
      w = peek(address_i);
      for (int b = 0; b < 4; b++)
        if (byteenable_i[b])
          w[8 * b +: 8] = writedata_i[8 * b +: 8];
      mem[address_i] = w;
    end
  end
endmodule : dma_mem_model

// ### sim/dma_channel_descriptor_status_bench.sv
/*
 Self-checking bench of the DMA channel with its memory model.
 Assumes descriptors at 0x8000, write-back at 0x9000, data below 0x8000.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin \
  compares++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); \
  end \
end
module dma_channel_descriptor_status_bench;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [9:0] avs_address_i = 10'h0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hf;
  logic trigger_i = 1'b0;
  logic priority_lost_i = 1'b0;
  logic [31:0] avs_readdata_o, m_address_o, m_writedata_o, m_readdata_i, q, ch, s, d;
  logic avs_waitrequest_o, m_read_o, m_write_o, m_waitrequest_i, event_o;
  logic [3:0] m_byteenable_o;
  logic [1:0] m_response_i;
  logic [31:0] err_addr = 32'hffffffff;
  logic slow = 1'b0;
  logic [15:0] c, n;
  logic [63:0] rt;
  logic [67:0] wt;
  logic [63:0] rq[$];
  logic [67:0] wq[$];
  logic [1:0] evo [3] = '{2'h0, 2'h1, 2'h3};
  logic [15:0] bad [3] = '{16'h0e01, 16'h0f01, 16'h0e05};
  int num_errors = 0;
  int compares = 0;
  int seed = 6;
  int ev_n = 0;
  always #25 sys_clk_i = ~sys_clk_i;
  dma_channel_descriptor_status u_dma_channel_descriptor_status (.*);
  dma_mem_model u_mem (.clk_i(sys_clk_i), .address_i(m_address_o), .read_i(m_read_o),
    .write_i(m_write_o), .writedata_i(m_writedata_o), .byteenable_i(m_byteenable_o),
    .err_addr_i(err_addr), .slow_i(slow), .readdata_o(m_readdata_i),
    .waitrequest_o(m_waitrequest_i), .response_o(m_response_i));
  always @(posedge sys_clk_i) begin
    if (event_o === 1'b1)
      ev_n++;
    if (avs_read_i && avs_waitrequest_o === 1'b0) begin
      rt = rq.pop_front();
      `CHK(avs_readdata_o & rt[31:0], rt[63:32])
    end
    if (m_write_o && m_waitrequest_i === 1'b0 && m_address_o < 32'h8000) begin
      wt = wq.pop_front();
      `CHK({m_address_o, m_byteenable_o, m_writedata_o}, wt)
    end
  end
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] v);
    int t;
    t = 0;
    avs_address_i <= a;
    avs_writedata_i <= v;
    avs_read_i <= ~w;
    avs_write_i <= w;
    do begin
      @(posedge sys_clk_i);
      t++;
    end while (avs_waitrequest_o !== 1'b0 && t < 40);
    q = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask : bus
  task automatic rd(input logic [9:0] a, input logic [31:0] e, input logic [31:0] m);
    rq.push_back({e & m, m});
    bus(1'b0, a, 32'h0);
  endtask : rd
  function automatic logic [31:0] al(input logic [31:0] b);
    return b + ($random(seed) & 32'h3ff & ~((32'h1 << c[9:8]) - 32'h1));
  endfunction : al
  task automatic put_desc(input logic [15:0] k, cnt, input logic [31:0] sa, da);
    u_mem.mem[32'h8000 + ch * 16] = {cnt, k & 16'hff1f};
    u_mem.mem[32'h8004 + ch * 16] = sa;
    u_mem.mem[32'h8008 + ch * 16] = da;
    u_mem.mem[32'h800c + ch * 16] = 32'h0;
  endtask : put_desc
  task automatic beats(input logic [15:0] k, input int cnt, f, l, input logic [31:0] se, de);
    logic [31:0] sz, si, di, sa, da, w;
    logic [3:0] be;
    sz = 32'h1 << k[9:8];
    si = k[10] ? (k[12] ? sz << k[15:13] : sz) : 32'h0;
    di = k[11] ? (k[12] ? sz : sz << k[15:13]) : 32'h0;
    for (int i = f; i < l; i++) begin
      sa = se - (cnt - i) * si;
      da = de - (cnt - i) * di;
      w = u_mem.peek({sa[31:2], 2'h0}) >> (8 * sa[1:0]);
      be = k[9] ? 4'hf : (k[8] ? 4'h3 : 4'h1) << da[1:0];
      wq.push_back({da[31:2], 2'h0, be, (k[9] ? w : k[8] ? {2{w[15:0]}} : {4{w[7:0]}})});
    end
  endtask : beats
  // Polls status; trigger drops once busy is seen so a lost channel stays pending
  task automatic go(input logic [31:0] cmd);
    int t;
    logic seen;
    t = 0;
    seen = 1'b0;
    ev_n = 0;
    if (cmd != 0)
      bus(1'b1, 10'h040, cmd);
    do begin
      trigger_i <= ~seen;
      rd(10'h13c, 32'h0, 32'h0);
      seen = seen | q[1];
      t++;
    end while ((t < 8 || q[1] || wq.size() != 0) && t < 300);
    trigger_i <= 1'b0;
  endtask : go
  task automatic conclude();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    num_errors++;
    conclude();
  end
  initial begin
    repeat (10) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    @(posedge sys_clk_i);
    rd(10'h13c, 32'h0, 32'hffffffff);
    bus(1'b1, 10'h13c, 32'hff);
    rd(10'h13c, 32'h0, 32'hffffffff);
    rd(10'h3fc, 32'h0, 32'hffffffff);
    ch = $random(seed) & 32'h7;
    bus(1'b1, 10'h04c, ch);
    bus(1'b1, 10'h044, 32'h8000);
    bus(1'b1, 10'h048, 32'h9000);
    rd(10'h04c, ch, 32'h7);
    $display("test setup done");
    for (int k = 0; k < 8; k++) begin
      c = {k[2:0], k[0], 2'($random(seed)), 2'(k % 3), 3'h0, k[1:0], evo[k % 3], 1'b1};
      n = 16'h1 + 16'($random(seed) & 3);
      s = al(32'h2000);
      d = al(32'h6000);
      slow <= k[2];
      put_desc(c, n, s, d);
      beats(c, n, 0, n, s, d);
      go(32'h1);
      rd(10'h13c, 32'h0, c[4] ? 32'hfe : 32'hff);
      rd(10'h054, 32'h0, 32'hffff);
      rd(10'h050, {c[4], c[3], 1'b0}, 32'h7);
      rd(10'h040, c[4], 32'h1);
      `CHK(ev_n, c[2:1] == 2'h3 ? n : c[2:1] == 2'h1 ? 1 : 0)
      `CHK(u_mem.peek(32'h9000 + ch * 16), {16'h0, c & 16'hff1e})
      bus(1'b1, 10'h040, {30'h0, c[4], c[4]});
      rd(10'h040, 32'h0, 32'h1);
      bus(1'b1, 10'h050, 32'h7);
      $display("test block %0d done", k);
    end
    put_desc(16'h0e00, 16'h2, 32'h2100, 32'h6100);
    go(32'h1);
    rd(10'h13c, 32'h4, 32'hff);
    rd(10'h050, 32'h5, 32'h7);
    bus(1'b1, 10'h050, 32'h7);
    put_desc(16'h0e01, 16'h2, 32'h2100, 32'h6100);
    beats(16'h0e01, 2, 0, 2, 32'h2100, 32'h6100);
    go(32'h3);
    rd(10'h13c, 32'h0, 32'hff);
    $display("test invalid descriptor done");
    for (int j = 0; j < 3; j++) begin
      err_addr <= (j == 0) ? 32'h21f8 : 32'hffffffff;
      u_mem.mem[32'h9000 + ch * 16] = 32'h1;
      put_desc(bad[j], 16'h2, 32'h2200, 32'h6200);
      go(32'h1);
      rd(10'h13c, 32'h0, 32'hff);
      rd(10'h050, 32'h1, 32'h1);
      rd(10'h040, 32'h0, 32'h1);
      `CHK(u_mem.peek(32'h9000 + ch * 16) & 32'h1, 32'h0)
      bus(1'b1, 10'h050, 32'h7);
      $display("test fault %0d done", j);
    end
    err_addr <= 32'hffffffff;
    slow <= 1'b1;
    priority_lost_i <= 1'b1;
    put_desc(16'h0e01, 16'h3, 32'h2400, 32'h6400);
    beats(16'h0e01, 3, 0, 1, 32'h2400, 32'h6400);
    go(32'h1);
    rd(10'h054, 32'h2, 32'hffff);
    rd(10'h13c, 32'h1, 32'hff);
    `CHK(u_mem.peek(32'h9000 + ch * 16), 32'h00020e01)
    priority_lost_i <= 1'b0;
    beats(16'h0e01, 3, 1, 3, 32'h2400, 32'h6400);
    go(32'h0);
    `CHK(u_mem.peek(32'h9000 + ch * 16), 32'h00000e00)
    `CHK(wq.size(), 0)
    $display("test priority loss done");
    conclude();
  end
endmodule : dma_channel_descriptor_status_bench
